// ---- design/twidc_regs.vh ----
/*
  Register map, field layout and reset values of the transmit DMA
  configuration block. Included by the design files; defines only.
*/
// Function
// - The byte limit holds the most bytes fetched per transaction, 1 to 0x3FFF.
// - After each transaction the sent byte count is updated and read-only.
// - A transaction ended by NACK counts the byte that was refused.
// - The low 7 address bits are the target address sent on the bus.
`ifndef TWIDC_REGS_VH
`define TWIDC_REGS_VH
`define TWIDC_OFF_TX_PTR     12'h0544
`define TWIDC_OFF_TX_MAX     12'h0548
`define TWIDC_OFF_TX_SENT    12'h054C
`define TWIDC_OFF_TX_LIST    12'h0550
`define TWIDC_OFF_ADDR       12'h0588
`define TWIDC_OFF_FIFO_STAT  12'h058C
`define TWIDC_CNT_W          14
`define TWIDC_CNT_MAX        14'h3FFF
`define TWIDC_LIST_W         3
`define TWIDC_LIST_OFF       3'h0
`define TWIDC_LIST_ARRAY     3'h1
`define TWIDC_ADDR_W         7
`define TWIDC_RST_WORD       32'h0000_0000
`define TWIDC_FIFO_W         8
`define TWIDC_FIFO_D         16
`endif

// ---- design/twidc_fifo.v ----
/*
  Synchronous FIFO with valid and ready on both sides.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module twidc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             i_clk,
  input  wire             i_rstn,
  input  wire [WIDTH-1:0] i_data,
  input  wire             i_valid,
  output wire             o_ready,
  output wire [WIDTH-1:0] o_data,
  output wire             o_valid,
  input  wire             i_ready,
  output wire [AW:0]      o_level
);
  // A sized copy of the depth keeps the full test free of a parameter
  // part-select, which strict front ends refuse.
  localparam [AW:0] FULL = DEPTH;

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wptr;
  reg [AW-1:0]    rptr;
  reg [AW:0]      level;
  wire            push;
  wire            pop;

  assign o_ready = (level != FULL);
  assign o_valid = (level != {(AW+1){1'b0}});
  assign o_data  = mem[rptr];
  assign o_level = level;
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;

  always @(posedge i_clk) begin
    if (push) begin
      mem[wptr] <= i_data;
    end
  end

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wptr  <= {AW{1'b0}};
      rptr  <= {AW{1'b0}};
      level <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wptr <= wptr + 1'b1;
      end
      if (pop) begin
        rptr <= rptr + 1'b1;
      end
      if (push && !pop) begin
        level <= level + 1'b1;
      end else if (pop && !push) begin
        level <= level - 1'b1;
      end
    end
  end
endmodule // twidc_fifo

// ---- design/twidc_top.v ----
/*
  Transmit DMA configuration, byte-count and target-address registers of
  a two-wire master, with an APB slave and a byte FIFO between the DMA
  reader and the bus engine. Assumes the engine reports each byte it
  put on the wire and a one-cycle end-of-transaction pulse.
*/
`timescale 1ns/1ps
`include "twidc_regs.vh"
module twidc_top #(
  parameter FIFO_W = `TWIDC_FIFO_W,
  parameter FIFO_D = `TWIDC_FIFO_D
) (
  input  wire                     i_clk,
  input  wire                     i_rstn,
  input  wire                     i_psel,
  input  wire                     i_penable,
  input  wire                     i_pwrite,
  input  wire [11:0]              i_paddr,
  input  wire [31:0]              i_pwdata,
  output reg  [31:0]              o_prdata,
  output reg                      o_pready,
  output reg                      o_pslverr,
  input  wire                     i_start,
  input  wire [FIFO_W-1:0]        i_dma_data,
  input  wire                     i_dma_valid,
  output reg                      o_dma_ready,
  output reg  [FIFO_W-1:0]        o_tx_data,
  output reg                      o_tx_valid,
  input  wire                     i_tx_ready,
  input  wire                     i_byte_sent,
  input  wire                     i_done,
  input  wire                     i_nack,
  output reg  [31:0]              o_buf_ptr,
  output reg  [`TWIDC_CNT_W-1:0]  o_max_count,
  output reg  [`TWIDC_ADDR_W-1:0] o_target_addr,
  output reg                      o_active,
  output reg                      o_limit_hit
);
  localparam ST_IDLE = 2'b01;
  localparam ST_RUN  = 2'b10;

  reg  [31:0]              tx_buffer_pointer;
  reg  [`TWIDC_CNT_W-1:0]  tx_max_byte_count;
  reg  [`TWIDC_CNT_W-1:0]  tx_bytes_sent;
  reg  [`TWIDC_LIST_W-1:0] tx_list_mode;
  reg  [`TWIDC_ADDR_W-1:0] slave_target_address;
  reg  [1:0]               state;
  reg  [`TWIDC_CNT_W-1:0]  run_count;
  reg  [`TWIDC_CNT_W-1:0]  fetched;
  reg  [31:0]              rdata;
  reg                      hit;
  wire                     wr_en;
  wire                     rd_en;
  wire                     fifo_ready;
  wire [FIFO_W-1:0]        fifo_data;
  wire                     fifo_valid;
  wire [4:0]               fifo_level;
  wire                     fetch_ok;
  wire                     take;
  wire                     pop_ok;
  wire                     load_tx;
  wire [31:0]              next_ptr;

  assign wr_en    = i_psel & i_penable & i_pwrite & o_pready;
  assign rd_en    = i_psel & ~i_penable & ~i_pwrite;
  // Fetch stops at the limit so no byte past the buffer end is read.
  assign fetch_ok = (state == ST_RUN) && (fetched < o_max_count);
  assign take     = i_dma_valid & o_dma_ready;
  assign pop_ok   = o_tx_valid & i_tx_ready;
  // The FIFO gives up its head only when the output stage takes it, so
  // no byte is sent twice.
  assign load_tx  = (pop_ok | ~o_tx_valid) & (state == ST_RUN);
  assign next_ptr = o_buf_ptr + {{(32-`TWIDC_CNT_W){1'b0}}, o_max_count};

  twidc_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_D),
    .AW    (4)
  ) u_fifo (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_data  (i_dma_data),
    .i_valid (take),
    .o_ready (fifo_ready),
    .o_data  (fifo_data),
    .o_valid (fifo_valid),
    .i_ready (load_tx),
    .o_level (fifo_level)
  );

  // Read data is registered in the setup cycle so the access ends in one.
  always @* begin
    hit   = 1'b1;
    rdata = `TWIDC_RST_WORD;
    if (i_paddr == `TWIDC_OFF_TX_PTR) begin
      rdata = tx_buffer_pointer;
    end else if (i_paddr == `TWIDC_OFF_TX_MAX) begin
      rdata[`TWIDC_CNT_W-1:0] = tx_max_byte_count;
    end else if (i_paddr == `TWIDC_OFF_TX_SENT) begin
      rdata[`TWIDC_CNT_W-1:0] = tx_bytes_sent;
    end else if (i_paddr == `TWIDC_OFF_TX_LIST) begin
      rdata[`TWIDC_LIST_W-1:0] = tx_list_mode;
    end else if (i_paddr == `TWIDC_OFF_ADDR) begin
      rdata[`TWIDC_ADDR_W-1:0] = slave_target_address;
    end else if (i_paddr == `TWIDC_OFF_FIFO_STAT) begin
      rdata[4:0] = fifo_level;
      rdata[8]   = o_active;
    end else begin
      hit = 1'b0;
    end
  end

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_prdata  <= `TWIDC_RST_WORD;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable & ~hit;
      if (rd_en) begin
        o_prdata <= rdata;
      end
    end
  end

  // The sent count register has no write path; software only reads it.
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_buffer_pointer    <= `TWIDC_RST_WORD;
      tx_max_byte_count    <= {`TWIDC_CNT_W{1'b0}};
      tx_list_mode         <= `TWIDC_LIST_OFF;
      slave_target_address <= {`TWIDC_ADDR_W{1'b0}};
    end else if (wr_en) begin
      if (i_paddr == `TWIDC_OFF_TX_PTR) begin
        tx_buffer_pointer <= i_pwdata;
      end else if (i_paddr == `TWIDC_OFF_TX_MAX) begin
        tx_max_byte_count <= i_pwdata[`TWIDC_CNT_W-1:0];
      end else if (i_paddr == `TWIDC_OFF_TX_LIST) begin
        tx_list_mode <= i_pwdata[`TWIDC_LIST_W-1:0];
      end else if (i_paddr == `TWIDC_OFF_ADDR) begin
        slave_target_address <= i_pwdata[`TWIDC_ADDR_W-1:0];
      end
    end
  end

  // Configuration is latched at start so software may reprogram it for
  // the next transaction while this one runs.
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state         <= ST_IDLE;
      o_buf_ptr     <= `TWIDC_RST_WORD;
      o_max_count   <= {`TWIDC_CNT_W{1'b0}};
      o_target_addr <= {`TWIDC_ADDR_W{1'b0}};
      o_active      <= 1'b0;
      o_limit_hit   <= 1'b0;
      run_count     <= {`TWIDC_CNT_W{1'b0}};
      fetched       <= {`TWIDC_CNT_W{1'b0}};
      tx_bytes_sent <= {`TWIDC_CNT_W{1'b0}};
      o_dma_ready   <= 1'b0;
      o_tx_valid    <= 1'b0;
      o_tx_data     <= {FIFO_W{1'b0}};
    end else begin
      o_dma_ready <= fetch_ok && fifo_ready && !(take && fifo_level[3:0]
                     == 4'hF) && !(take && fetched + 1'b1 >= o_max_count);
      if (pop_ok || !o_tx_valid) begin
        o_tx_valid <= fifo_valid && (state == ST_RUN);
        o_tx_data  <= fifo_data;
      end
      if (take) begin
        fetched <= fetched + 1'b1;
      end
      case (state)
        ST_IDLE: begin
          if (i_start) begin
            state         <= ST_RUN;
            o_active      <= 1'b1;
            o_limit_hit   <= 1'b0;
            o_target_addr <= slave_target_address;
            o_max_count   <= tx_max_byte_count;
            run_count     <= {`TWIDC_CNT_W{1'b0}};
            fetched       <= {`TWIDC_CNT_W{1'b0}};
            if (tx_list_mode == `TWIDC_LIST_ARRAY && o_active == 1'b0
                && o_buf_ptr != `TWIDC_RST_WORD) begin
              o_buf_ptr <= next_ptr;
            end else begin
              o_buf_ptr <= tx_buffer_pointer;
            end
          end
        end
        ST_RUN: begin
          if (i_byte_sent && run_count != o_max_count) begin
            run_count <= run_count + 1'b1;
          end
          if (run_count == o_max_count && o_max_count != 0) begin
            o_limit_hit <= 1'b1;
          end
          if (i_done) begin
            state    <= ST_IDLE;
            o_active <= 1'b0;
            o_dma_ready <= 1'b0;
            // A byte refused by NACK still left the wire, so it counts.
            if (i_nack && i_byte_sent) begin
              tx_bytes_sent <= run_count + 1'b1;
            end else if (i_nack) begin
              tx_bytes_sent <= run_count;
            end else begin
              tx_bytes_sent <= run_count + {13'h0000, i_byte_sent};
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // twidc_top

// ---- verif/twidc_props.sv ----
/*
  Assertions on the ports of the transmit DMA configuration block.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module twidc_props (
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_start,
  input wire logic        i_done,
  input wire logic        i_nack,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        o_active,
  input wire logic        o_dma_ready,
  input wire logic        o_limit_hit,
  input wire logic [31:0] o_buf_ptr,
  input wire logic [6:0]  o_target_addr
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  chk_apb_answer: assert property (i_psel && !i_penable |=>
    o_pready ##1 !o_pready) else $error("pready not one cycle after setup");
  chk_err_pairs: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  chk_start_run: assert property (i_start && !o_active |=> o_active)
    else $error("start not taken while idle");
  chk_done_stop: assert property (o_active && i_done |=> !o_active)
    else $error("transaction did not end on done");
  chk_addr_held: assert property (o_active |=> $stable(o_target_addr))
    else $error("target address moved during a transaction");
  chk_ptr_held: assert property (o_active |=> $stable(o_buf_ptr))
    else $error("buffer pointer moved during a transaction");
  chk_limit_stop: assert property (o_active && o_limit_hit |=>
    !o_dma_ready) else $error("fetch continued past the limit");
  cover property (o_pslverr);
  cover property (o_active && i_done && i_nack);
  cover property (o_active && !o_dma_ready && !o_limit_hit);
endmodule // twidc_props

bind twidc_top twidc_props twidc_props_inst (.i_clk, .i_rstn, .i_psel,
  .i_penable, .i_start, .i_done, .i_nack, .o_pready, .o_pslverr, .o_active,
  .o_dma_ready, .o_limit_hit, .o_buf_ptr, .o_target_addr);

// ---- verif/twidc_engine_model.sv ----
/*
  Behavioural bus engine that drains the byte stream toward the slave.
  Assumes the bench sets the byte total and NACK choice before a start.
*/
`timescale 1ns/1ps
module twidc_engine_model (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_tx_valid,
  input  wire logic        i_hold,
  input  wire logic        i_nack_mode,
  input  wire logic [13:0] i_target,
  output logic             o_tx_ready,
  output logic             o_byte_sent,
  output logic             o_done,
  output logic             o_nack
);
  logic [13:0] sent;
  logic        take;
  // A held engine models a slave stretching the clock.
  assign o_tx_ready = !i_hold;
  assign take = i_tx_valid && o_tx_ready;
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sent <= 14'h0000;
      o_byte_sent <= 1'b0;
      o_done <= 1'b0;
      o_nack <= 1'b0;
    end else begin
      o_byte_sent <= take;
      o_done <= take && (sent + 14'h0001 == i_target);
      o_nack <= take && (sent + 14'h0001 == i_target) && i_nack_mode;
      if (take)
        sent <= (sent + 14'h0001 == i_target) ? 14'h0000 : sent + 14'h0001;
    end
  end
endmodule // twidc_engine_model

// ---- verif/test_twidc_top.sv ----
/*
  Self-checking bench: APB register tests and two transmit transactions.
  Assumes the engine model stands on the byte stream side.
*/
`timescale 1ns/1ps
module test_twidc_top;
  logic        i_clk = 0, i_rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        start = 0, dvalid = 0, hold = 0, nkm = 0, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, ptr, rd;
  logic [13:0] tgt = 14'h0001, mcnt;
  logic [7:0]  ddata = 0, txd, texp = 0;
  logic [6:0]  taddr;
  logic        pready, pslverr, dready, txv, txr, sent, done, nack, act, lim;
  int          err_count = 0, checked = 0, cyc = 0;
  logic [11:0] offs [5] = '{12'h0544, 12'h0548, 12'h054C, 12'h0550, 12'h0588};
  logic [31:0] msk [5] = '{32'hFFFF_FFFF, 32'h0000_3FFF, 32'h0000_0000,
                           32'h0000_0007, 32'h0000_007F};
  twidc_top twidc_top_inst (.i_clk, .i_rstn, .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_start(start), .i_dma_data(ddata),
    .i_dma_valid(dvalid), .o_dma_ready(dready), .o_tx_data(txd),
    .o_tx_valid(txv), .i_tx_ready(txr), .i_byte_sent(sent), .i_done(done),
    .i_nack(nack), .o_buf_ptr(ptr), .o_max_count(mcnt),
    .o_target_addr(taddr), .o_active(act), .o_limit_hit(lim));
  twidc_engine_model twidc_engine_model_inst (.i_clk, .i_rstn,
    .i_tx_valid(txv), .i_hold(hold), .i_nack_mode(nkm), .i_target(tgt),
    .o_tx_ready(txr), .o_byte_sent(sent), .o_done(done), .o_nack(nack));
  initial forever #4 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (dvalid && dready)
      ddata <= ddata + 8'h01;
    // Bytes must leave in fetch order, each exactly once.
    if (txv && txr) begin
      checked++;
      if (txd !== texp) begin
        err_count++;
        $display("mismatch tx_data expected %h seen %h", texp, txd);
      end
      texp <= texp + 8'h01;
    end
    // The whole run needs well under a thousand cycles.
    if (cyc == 20000) begin
      err_count++;
      final_report;
    end
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1;
    @(posedge i_clk);
    while (pready !== 1'b1)
      @(posedge i_clk);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic run(input logic [13:0] n, input logic nk, input logic [31:0] p);
    tgt <= n;
    nkm <= nk;
    @(posedge i_clk);
    start <= 1;
    @(posedge i_clk);
    start <= 0;
    @(posedge i_clk);
    chk("target", 32'h0000_0055, {25'h0, taddr});
    chk("pointer", p, ptr);
    chk("limit", 32'h0000_0014, {18'h0, mcnt});
    if (hold) begin
      // The engine stalls, so the fetch side must meet a full buffer.
      repeat (40) @(posedge i_clk);
      chk("fifo full", 32'h0000_0000, {31'h0, dready});
      hold <= 0;
    end
    while (act === 1'b1)
      @(posedge i_clk);
  endtask
  initial begin
    repeat (20) @(posedge i_clk);
    i_rstn <= 1;
    dvalid <= 1;
    for (int i = 0; i < 5; i++) begin
      apb(0, offs[i], 0);
      chk("reset", 32'h0000_0000, rd);
      apb(1, offs[i], 32'hFFFF_FFFF);
      apb(0, offs[i], 0);
      chk("field", msk[i], rd);
    end
    apb(1, 12'h0600, 32'h0000_0001);
    chk("unmapped", 32'h0000_0001, {31'h0, er});
    apb(1, 12'h0544, 32'h0000_0100);
    apb(1, 12'h0548, 32'h0000_0014);
    apb(1, 12'h0550, 32'h0000_0000);
    apb(1, 12'h0588, 32'hFFFF_FFD5);
    hold <= 1;
    run(14'h0014, 0, 32'h0000_0100);
    apb(0, 12'h054C, 0);
    chk("sent", 32'h0000_0014, rd);
    apb(1, 12'h0550, 32'h0000_0001);
    run(14'h0002, 1, 32'h0000_0114);
    apb(0, 12'h054C, 0);
    chk("sent nack", 32'h0000_0002, rd);
    final_report;
  end
endmodule // test_twidc_top
